// [shared/mta_pkg.sv]
// Purpose: Shared constants and types of the address-table aging and interrupt block
// Assumes: 100 MHz core clock, 32-bit AHB-Lite register bus
// Notes:   Register byte offsets, field positions, reset values and tick counts

package mta_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned MAC_W  = 48;
  localparam int unsigned FID_W  = 12;
  localparam int unsigned AGE_W  = 2;
  localparam int unsigned CLS_W  = 2;
  localparam int unsigned PORT_W = 5;
  localparam int unsigned N_CLS  = 4;
  localparam int unsigned PER_W  = 16;
  localparam int unsigned MC_BIT = 40;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_AGE_CFG0   = 8'h00;
  localparam logic [7:0] OFS_CTRL       = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_EVENT      = 8'h18;
  localparam logic [7:0] OFS_LOCAL_FILT = 8'h1C;
  localparam logic [7:0] OFS_VMAP       = 8'h20;
  localparam logic [7:0] OFS_IRQ_LATCH  = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h28;
  localparam logic [7:0] OFS_IRQ_VIEW   = 8'h2C;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned AC_UNIT_LSB   = 0;
  localparam int unsigned AC_PER_LSB    = 4;
  localparam int unsigned AC_HOLD_BIT   = 31;
  localparam int unsigned CT_KICK       = 0;
  localparam int unsigned CT_ABORT      = 1;
  localparam int unsigned CT_HALT       = 2;
  localparam int unsigned CT_APPLY      = 3;
  localparam int unsigned CT_REMOTE     = 4;
  localparam int unsigned CT_AGE_PIN    = 5;
  localparam int unsigned CT_OPDONE     = 6;
  localparam int unsigned CT_AGEMAX_LSB = 8;
  localparam int unsigned ST_BUSY_BIT   = 16;
  localparam int unsigned EV_DONE       = 0;
  localparam int unsigned EV_BEGUN      = 1;
  localparam int unsigned EV_COUNTED    = 2;
  localparam int unsigned EV_PURGED     = 3;
  localparam int unsigned VM_VID_LSB    = 16;
  localparam int unsigned IRQ_RULE      = 0;
  localparam int unsigned IRQ_PORT      = 1;
  localparam int unsigned IRQ_GROUP     = 2;
  localparam int unsigned IRQ_SVC       = 3;
  localparam int unsigned IRQ_OPDONE    = 4;
  localparam int unsigned IRQ_N         = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [AGE_W-1:0] AGE_MAX_RST  = 2'h1;
  localparam logic [31:0]      LOCAL_FILT_RST = 32'h0000_0000;

  // ****************************************************************
  // Tick units and timing
  // ****************************************************************
  localparam logic [1:0]  UNIT_OFF = 2'h0;
  localparam logic [1:0]  UNIT_US  = 2'h1;
  localparam logic [1:0]  UNIT_MS  = 2'h2;
  localparam logic [1:0]  UNIT_S   = 2'h3;
  localparam int unsigned CLK_NS   = 10;
  localparam int unsigned US_NS    = 1000;
  localparam int unsigned US_CYC   = US_NS / CLK_NS;
  localparam int unsigned UNIT_MUL = 1000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic              valid;
    logic              pinned;
    logic              remote;
    logic [CLS_W-1:0]  cls;
    logic [AGE_W-1:0]  age;
    logic [PORT_W-1:0] port;
    logic [FID_W-1:0]  filtering_group_id;
    logic [MAC_W-1:0]  mac;
  } mta_entry_t;

  typedef struct packed {
    logic             hold;
    logic [PER_W-1:0] period;
    logic [1:0]       unit;
  } mta_age_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
  } mta_ahb_req_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b01,
    SW_SCAN = 2'b10
  } mta_sweep_state_t;

endpackage

// [testbench/mta_aging_props.sv]
// Purpose: Port-level timing checks for mta_aging
// Assumes: One slave, its hreadyout is the bus hready
// Notes:   Bound into every mta_aging instance
`timescale 1ns/1ns

module mta_aging_props (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Bus
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Lookup and interrupt causes
  input wire logic       src_valid,
  input wire logic       src_known,
  input wire logic       rule_hit,
  input wire logic       port_exceed,
  input wire logic       group_exceed,
  input wire logic       svc_exceed,
  input wire logic       table_op_done,
  input wire logic       analyzer_irq
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic tk, wr, cause;
  assign tk    = hsel && hready && htrans[1];
  assign wr    = tk && hwrite;
  assign cause = rule_hit | port_exceed | group_exceed | svc_exceed | table_op_done;
  sequence rd_take;
    tk && !hwrite;
  endsequence
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  resp_okay_a: assert property (!hresp) else $error("response not okay");
  rd_wait_a: assert property (rd_take |=> rd_answer) else $error("read wait wrong");
  wr_nowait_a: assert property (wr |=> hreadyout) else $error("write stalled");
  wait_cause_a: assert property (!hreadyout |-> $past(tk && !hwrite)) else $error("stray wait");
  wait_once_a: assert property (!hreadyout |=> hreadyout) else $error("long wait");
  known_cause_a: assert property (src_known |-> $past(src_valid)) else $error("stray hit");
  irq_rise_a: assert property ($rose(analyzer_irq) |-> $past(cause, 2) || $past(cause, 3)
    || $past(wr, 3) || $past(wr, 4) || $past(wr, 5)) else $error("irq rose alone");
  irq_fall_a: assert property ($fell(analyzer_irq) |-> $past(wr, 3) || $past(wr, 4)
    || $past(wr, 5)) else $error("irq fell alone");
endmodule

bind mta_aging mta_aging_props i_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .src_valid, .src_known, .rule_hit, .port_exceed, .group_exceed,
  .svc_exceed, .table_op_done, .analyzer_irq);

// [testbench/mta_aging_tb.sv]
// Purpose: Self-checking bench for mta_aging
// Assumes: Expected values are fixed in the sequence below or computed from its stimulus
// Notes:   One timer unit is 100 cycles
`timescale 1ns/1ns

module mta_aging_tb;
  import mta_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, src_valid, src_known;
  logic        ins_valid, analyzer_irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [47:0] src_mac;
  logic [5:0]  src_vid;
  logic [3:0]  ins_row, qu, q;
  logic [4:0]  ev;
  mta_entry_t  ins_entry;
  int          fail_count, check_count, lat, msk;
  localparam logic [47:0] UC = 48'h0000_0012_3456;
  localparam logic [47:0] MC = 48'h0100_00AB_CDEF;

  mta_aging i_mta_aging (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .src_valid, .src_mac,
    .src_vid, .src_known, .ins_valid, .ins_row, .ins_entry, .rule_hit(ev[0]),
    .rule_hit_irq_req(qu[0]), .port_exceed(ev[1]), .port_exceed_irq_en(qu[1]),
    .group_exceed(ev[2]), .group_exceed_irq_en(qu[2]), .svc_exceed(ev[3]),
    .svc_exceed_irq_en(qu[3]), .table_op_done(ev[4]), .analyzer_irq);

  // ****************
  // Tasks
  // ****************
  task summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wt;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n == 40) begin
      fail_count++;
      summarize;
    end
    @(posedge hclk);
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk) {hsel, htrans, hwrite, haddr} <= {3'b110, w, 24'h0, a};
    wt;
    {hsel, htrans, hwdata} <= {3'b000, d};
    wt;
    r = hrdata;
  endtask
  task idle;
    int n;
    n = 0;
    do begin
      ahb(0, OFS_STATUS, 0);
      n++;
    end while (r[ST_BUSY_BIT] !== 1'b0 && n < 40);
    if (n == 40) begin
      fail_count++;
      summarize;
    end
  endtask
  task lk(input logic [47:0] m, input logic [5:0] v, input logic e);
    @(posedge hclk) {src_valid, src_mac, src_vid} <= {1'b1, m, v};
    @(posedge hclk) src_valid <= 1'b0;
    #1 chk(32'(src_known), 32'(e));
  endtask
  task ins(input logic [3:0] w, input logic p, input logic [11:0] f, input logic [47:0] m);
    @(posedge hclk) {ins_valid, ins_row} <= {1'b1, w};
    ins_entry <= '{valid: 1'b1, pinned: p, filtering_group_id: f, mac: m, default: '0};
    @(posedge hclk) ins_valid <= 1'b0;
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, src_valid, src_mac, src_vid} = '0;
    {ins_valid, ins_row, ins_entry, qu, ev, fail_count, check_count} = '0;
    void'($urandom(32'h25C5));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1, 8'h40, 32'hFFFF_FFFF);
    ahb(0, 8'h40, 0);
    chk(r, 0);
    ahb(0, OFS_CTRL, 0);
    chk(r, 32'h100);
    ahb(0, OFS_AGE_CFG0, 0);
    chk(r, 0);
    msk = $urandom & 32'h1F;
    ahb(1, OFS_IRQ_MASK, msk);
    ahb(1, OFS_CTRL, 32'h140);
    q = 4'($urandom);
    for (int i = 0; i < 2; i++) begin
      @(posedge hclk) {ev, qu} <= {5'h1F, q};
      @(posedge hclk) ev <= 5'h0;
      lat = {1'b1, q};
      ahb(0, OFS_IRQ_LATCH, 0);
      chk(r, lat);
      ahb(0, OFS_IRQ_VIEW, 0);
      chk(r, lat & msk);
      chk(32'(analyzer_irq), 32'(|(lat & msk)));
      ahb(1, OFS_IRQ_LATCH, 32'h1F);
      ahb(0, OFS_IRQ_LATCH, 0);
      chk(r, 0);
      q = ~q;
    end
    ahb(1, OFS_VMAP, 32'h0003_0007);
    ahb(1, OFS_VMAP, 32'h0004_0007);
    ahb(1, OFS_VMAP, 32'h0005_0008);
    ins(2, 0, 7, UC);
    ins(5, 1, 3, MC);
    lk(UC, 4, 1);
    lk(UC, 5, 0);
    lk(MC, 3, 1);
    lk(MC, 4, 0);
    ahb(1, OFS_EVENT, 32'hF);
    ahb(1, OFS_CTRL, 32'h141);
    idle;
    ahb(0, OFS_EVENT, 0);
    chk(r, 32'h7);
    ahb(1, OFS_EVENT, 32'hF);
    ahb(1, OFS_AGE_CFG0, 32'h11);
    repeat (250) @(posedge hclk);
    ahb(1, OFS_AGE_CFG0, 32'h8000_0011);
    idle;
    chk(r, 0);
    ahb(0, OFS_EVENT, 0);
    chk(r, 32'hB);
    lk(UC, 3, 0);
    lk(MC, 3, 1);
    ahb(1, OFS_EVENT, 32'hF);
    repeat (250) @(posedge hclk);
    ahb(0, OFS_EVENT, 0);
    chk(r, 0);
    ahb(1, OFS_AGE_CFG0, 32'h11);
    repeat (250) @(posedge hclk);
    ahb(0, OFS_EVENT, 0);
    chk(r, 32'h3);
    ahb(1, OFS_CTRL, 32'h144);
    idle;
    ahb(1, OFS_EVENT, 32'hF);
    repeat (250) @(posedge hclk);
    ahb(0, OFS_EVENT, 0);
    chk(r, 0);
    summarize;
  end
endmodule

// [verilog/mta_age_timer.sv]
// Purpose: Sweep period timer for one age-interval class
// Assumes: Tick enables are one-cycle pulses from the shared divider
// Notes:   Count freezes while held and clears while the unit is off

`timescale 1ns/1ns

module mta_age_timer
  import mta_pkg::*;
(
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Tick enables
  input  wire logic         tick_us,
  input  wire logic         tick_ms,
  input  wire logic         tick_s,
  // Configuration
  input  wire mta_age_cfg_t cfg,
  // Sweep request pulse
  output logic              fire
);

  logic [PER_W-1:0] cnt_r;
  logic             tick;
  logic             last;

  always_comb begin
    unique case (cfg.unit)
      UNIT_US: tick = tick_us;
      UNIT_MS: tick = tick_ms;
      UNIT_S:  tick = tick_s;
      default: tick = 1'b0;
    endcase
  end

  assign last = (cnt_r + PER_W'(1)) >= cfg.period;
  assign fire = tick & !cfg.hold & (cfg.unit != UNIT_OFF) & last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else if (cfg.unit == UNIT_OFF) begin
      cnt_r <= '0;
    end else if (tick && !cfg.hold) begin
      cnt_r <= last ? '0 : cnt_r + PER_W'(1);
    end
  end

endmodule

// [verilog/mta_aging.sv]
// Purpose: Address-table store with source-hit activity clear, periodic aging sweep,
//          and analyzer interrupt latch, mask and view, behind an AHB-Lite slave
// Assumes: Learning path inserts entries and presents source lookups one per cycle
// Notes:   One table row is swept per clock cycle
//
// How it works
// - Entries keyed by address and group id
// - Group sharing applies to unicast only
// - Source hit clears activity counter
// - Pinned entries cleared only if enabled
// - Sweep considers unpinned entries only
// - At maximum delete, else count up
// - Four timers, one per interval class
// - Period from tick unit and tick count
// - Unit size zero stops periodic aging
// - Hold bit pauses, release resumes
// - Kick starts, abort stops sweep at once
// - Finish current sweep, then start none from timers
// - Port and remote filters when applied
// - Next row, busy, begun and done flags
// - Sticky flags for count-up and delete
// - Timers repeat sweeps without software
// - Sticky sources, mask, active view
// - Rule hit with irq action raises source
// - Port quota exceed raises source if enabled
// - Group quota exceed raises source if enabled
// - Service quota exceed raises if enabled
// - Table operation done raises if enabled
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.

`timescale 1ns/1ns

module mta_aging
  import mta_pkg::*;
#(
  parameter int unsigned ROWS   = 16,
  parameter int unsigned ROW_W  = 4,
  parameter int unsigned N_VLAN = 64,
  parameter int unsigned VID_W  = 6
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Source lookup from the learning path
  input  wire logic              src_valid,
  input  wire logic [MAC_W-1:0]  src_mac,
  input  wire logic [VID_W-1:0]  src_vid,
  output logic                   src_known,
  // Entry insert from the learning path
  input  wire logic              ins_valid,
  input  wire logic [ROW_W-1:0]  ins_row,
  input  wire mta_entry_t        ins_entry,
  // Interrupt sources
  input  wire logic              rule_hit,
  input  wire logic              rule_hit_irq_req,
  input  wire logic              port_exceed,
  input  wire logic              port_exceed_irq_en,
  input  wire logic              group_exceed,
  input  wire logic              group_exceed_irq_en,
  input  wire logic              svc_exceed,
  input  wire logic              svc_exceed_irq_en,
  input  wire logic              table_op_done,
  // Interrupt output
  output logic                   analyzer_irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  mta_entry_t       tab_r [ROWS];
  logic [FID_W-1:0] vlan_group_map_r [N_VLAN];
  mta_age_cfg_t     age_cfg_r [N_CLS];
  mta_ahb_req_t     req_r;
  mta_sweep_state_t state_r;

  logic             wr_ph_r;
  logic             rd_ph_r;
  logic             rd_rdy_r;
  logic [31:0]      hrdata_r;
  logic             acc;
  logic             wr_en;
  logic [31:0]      rd_mux;

  logic             finish_then_halt_r;
  logic             apply_port_filters_r;
  logic             remote_entry_filter_on_r;
  logic             age_pinned_entries_r;
  logic             op_done_irq_on_r;
  logic [AGE_W-1:0] age_max_r;
  logic [31:0]      local_port_filter_on_r;
  logic [VID_W-1:0] vm_sel_r;
  logic             sweep_kick;
  logic             sweep_abort;

  logic [3:0]       ev_r;
  logic [3:0]       ev_set;
  logic [IRQ_N-1:0] irq_source_latch_r;
  logic [IRQ_N-1:0] irq_source_mask_r;
  logic [IRQ_N-1:0] irq_set;
  logic [IRQ_N-1:0] irq_active_view;
  logic             analyzer_irq_r;

  logic [6:0]       us_cnt_r;
  logic [9:0]       ms_cnt_r;
  logic [9:0]       s_cnt_r;
  logic             tick_us;
  logic             tick_ms;
  logic             tick_s;
  logic [N_CLS-1:0] fire;
  logic [N_CLS-1:0] pend_r;
  logic [N_CLS-1:0] cls_r;
  logic [ROW_W-1:0] row_r;

  logic             start;
  logic             last_row;
  mta_entry_t       cur;
  logic             filt_ok;
  logic             cand;
  logic             clash;
  logic             do_up;
  logic             do_del;

  logic [FID_W-1:0] key_fid;
  logic             hit;
  logic [ROW_W-1:0] hit_row;
  logic             clear_ok;
  logic             src_known_r;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [7:0] cfg_ofs(input int unsigned i);
    return OFS_AGE_CFG0 + 8'(4 * i);
  endfunction

  // ****************************************************************
  // AHB-Lite slave: writes zero wait, reads one wait state
  // ****************************************************************
  assign acc       = hsel & hready & htrans[1];
  assign wr_en     = wr_ph_r;
  assign hreadyout = !(rd_ph_r & !rd_rdy_r);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r    <= '0;
      wr_ph_r  <= 1'b0;
      rd_ph_r  <= 1'b0;
      rd_rdy_r <= 1'b0;
    end else begin
      wr_ph_r  <= acc & hwrite;
      rd_rdy_r <= rd_ph_r & !rd_rdy_r;
      if (acc) begin
        req_r   <= '{addr: haddr[7:0], write: hwrite};
        rd_ph_r <= !hwrite;
      end else if (rd_rdy_r) begin
        rd_ph_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_ph_r && !rd_rdy_r) begin
      hrdata_r <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < N_CLS; i++) begin
      if (is_reg(req_r.addr, cfg_ofs(i))) begin
        rd_mux[AC_HOLD_BIT]                 = age_cfg_r[i].hold;
        rd_mux[AC_PER_LSB +: PER_W]         = age_cfg_r[i].period;
        rd_mux[AC_UNIT_LSB +: 2]            = age_cfg_r[i].unit;
      end
    end
    if (is_reg(req_r.addr, OFS_CTRL)) begin
      rd_mux[CT_HALT]                 = finish_then_halt_r;
      rd_mux[CT_APPLY]                = apply_port_filters_r;
      rd_mux[CT_REMOTE]               = remote_entry_filter_on_r;
      rd_mux[CT_AGE_PIN]              = age_pinned_entries_r;
      rd_mux[CT_OPDONE]               = op_done_irq_on_r;
      rd_mux[CT_AGEMAX_LSB +: AGE_W]  = age_max_r;
    end
    if (is_reg(req_r.addr, OFS_STATUS)) begin
      rd_mux[ROW_W-1:0]   = row_r;
      rd_mux[ST_BUSY_BIT] = state_r == SW_SCAN;
    end
    if (is_reg(req_r.addr, OFS_EVENT))      rd_mux[3:0] = ev_r;
    if (is_reg(req_r.addr, OFS_LOCAL_FILT)) rd_mux = local_port_filter_on_r;
    if (is_reg(req_r.addr, OFS_VMAP)) begin
      rd_mux[VM_VID_LSB +: VID_W] = vm_sel_r;
      rd_mux[FID_W-1:0]           = vlan_group_map_r[vm_sel_r];
    end
    if (is_reg(req_r.addr, OFS_IRQ_LATCH)) rd_mux[IRQ_N-1:0] = irq_source_latch_r;
    if (is_reg(req_r.addr, OFS_IRQ_MASK))  rd_mux[IRQ_N-1:0] = irq_source_mask_r;
    if (is_reg(req_r.addr, OFS_IRQ_VIEW))  rd_mux[IRQ_N-1:0] = irq_active_view;
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N_CLS; i++) begin
        age_cfg_r[i] <= '0;
      end
    end else if (wr_en) begin
      for (int i = 0; i < N_CLS; i++) begin
        if (is_reg(req_r.addr, cfg_ofs(i))) begin
          age_cfg_r[i] <= '{hold:   hwdata[AC_HOLD_BIT],
                            period: hwdata[AC_PER_LSB +: PER_W],
                            unit:   hwdata[AC_UNIT_LSB +: 2]};
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      finish_then_halt_r       <= 1'b0;
      apply_port_filters_r     <= 1'b0;
      remote_entry_filter_on_r <= 1'b0;
      age_pinned_entries_r     <= 1'b0;
      op_done_irq_on_r         <= 1'b0;
      age_max_r                <= AGE_MAX_RST;
      local_port_filter_on_r   <= LOCAL_FILT_RST;
      irq_source_mask_r        <= '0;
    end else if (wr_en) begin
      if (is_reg(req_r.addr, OFS_CTRL)) begin
        finish_then_halt_r       <= hwdata[CT_HALT];
        apply_port_filters_r     <= hwdata[CT_APPLY];
        remote_entry_filter_on_r <= hwdata[CT_REMOTE];
        age_pinned_entries_r     <= hwdata[CT_AGE_PIN];
        op_done_irq_on_r         <= hwdata[CT_OPDONE];
        age_max_r                <= hwdata[CT_AGEMAX_LSB +: AGE_W];
      end
      if (is_reg(req_r.addr, OFS_LOCAL_FILT)) local_port_filter_on_r <= hwdata;
      if (is_reg(req_r.addr, OFS_IRQ_MASK))   irq_source_mask_r <= hwdata[IRQ_N-1:0];
    end
  end

  // Self-clearing controls exist only as write pulses
  assign sweep_kick  = wr_en & is_reg(req_r.addr, OFS_CTRL) & hwdata[CT_KICK];
  assign sweep_abort = wr_en & is_reg(req_r.addr, OFS_CTRL) & hwdata[CT_ABORT];

  // Map is not reset; software loads each VLAN before use
  always_ff @(posedge hclk) begin
    if (wr_en && is_reg(req_r.addr, OFS_VMAP)) begin
      vlan_group_map_r[hwdata[VM_VID_LSB +: VID_W]] <= hwdata[FID_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vm_sel_r <= '0;
    end else if (wr_en && is_reg(req_r.addr, OFS_VMAP)) begin
      vm_sel_r <= hwdata[VM_VID_LSB +: VID_W];
    end
  end

  // ****************************************************************
  // Sticky events and interrupts: set wins over write-one-clear
  // ****************************************************************
  assign ev_set[EV_BEGUN]   = start;
  assign ev_set[EV_DONE]    = state_r == SW_SCAN && last_row && !sweep_abort;
  assign ev_set[EV_COUNTED] = do_up;
  assign ev_set[EV_PURGED]  = do_del;

  assign irq_set[IRQ_RULE]   = rule_hit & rule_hit_irq_req;
  assign irq_set[IRQ_PORT]   = port_exceed & port_exceed_irq_en;
  assign irq_set[IRQ_GROUP]  = group_exceed & group_exceed_irq_en;
  assign irq_set[IRQ_SVC]    = svc_exceed & svc_exceed_irq_en;
  assign irq_set[IRQ_OPDONE] = table_op_done & op_done_irq_on_r;
  assign irq_active_view     = irq_source_latch_r & irq_source_mask_r;
  assign analyzer_irq        = analyzer_irq_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_r <= '0;
    end else begin
      ev_r <= (ev_r & ~((wr_en && is_reg(req_r.addr, OFS_EVENT)) ? hwdata[3:0] : 4'h0))
              | ev_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_source_latch_r <= '0;
      analyzer_irq_r     <= 1'b0;
    end else begin
      irq_source_latch_r <= (irq_source_latch_r
                            & ~((wr_en && is_reg(req_r.addr, OFS_IRQ_LATCH))
                                ? hwdata[IRQ_N-1:0] : '0))
                            | irq_set;
      analyzer_irq_r     <= |irq_active_view;
    end
  end

  // ****************************************************************
  // Tick divider: microsecond, millisecond, second
  // ****************************************************************
  assign tick_us = us_cnt_r == 7'(US_CYC - 1);
  assign tick_ms = tick_us & (ms_cnt_r == 10'(UNIT_MUL - 1));
  assign tick_s  = tick_ms & (s_cnt_r == 10'(UNIT_MUL - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      us_cnt_r <= '0;
      ms_cnt_r <= '0;
      s_cnt_r  <= '0;
    end else begin
      us_cnt_r <= tick_us ? '0 : us_cnt_r + 7'h1;
      if (tick_us) ms_cnt_r <= tick_ms ? '0 : ms_cnt_r + 10'h1;
      if (tick_ms) s_cnt_r  <= tick_s ? '0 : s_cnt_r + 10'h1;
    end
  end

  generate
    for (genvar c = 0; c < N_CLS; c++) begin : g_timer
      mta_age_timer u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick_us (tick_us),
        .tick_ms (tick_ms),
        .tick_s  (tick_s),
        .cfg     (age_cfg_r[c]),
        .fire    (fire[c])
      );
    end
  endgenerate

  // ****************************************************************
  // Sweep control
  // ****************************************************************
  assign start    = state_r == SW_IDLE && (sweep_kick || (pend_r != '0 && !finish_then_halt_r));
  assign last_row = row_r == ROW_W'(ROWS - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= SW_IDLE;
      pend_r  <= '0;
      cls_r   <= '0;
      row_r   <= '0;
    end else begin
      pend_r <= (start ? '0 : pend_r) | fire;
      unique case (state_r)
        SW_IDLE: begin
          if (start) begin
            state_r <= SW_SCAN;
            cls_r   <= sweep_kick ? {N_CLS{1'b1}} : pend_r;
            row_r   <= '0;
          end
        end
        SW_SCAN: begin
          if (sweep_abort || last_row) begin
            state_r <= SW_IDLE;
            row_r   <= '0;
          end else begin
            row_r <= row_r + ROW_W'(1);
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Sweep row action
  // ****************************************************************
  assign cur     = tab_r[row_r];
  assign filt_ok = !apply_port_filters_r
                   || (cur.remote ? remote_entry_filter_on_r
                                  : local_port_filter_on_r[cur.port]);
  assign cand    = state_r == SW_SCAN && !sweep_abort && cur.valid && !cur.pinned
                   && cls_r[cur.cls] && filt_ok;
  assign clash   = (clear_ok && hit_row == row_r) || (ins_valid && ins_row == row_r);
  assign do_del  = cand && !clash && cur.age == age_max_r;
  assign do_up   = cand && !clash && cur.age != age_max_r;

  // ****************************************************************
  // Source lookup
  // ****************************************************************
  assign key_fid = src_mac[MC_BIT] ? FID_W'(src_vid) : vlan_group_map_r[src_vid];

  always_comb begin
    hit     = 1'b0;
    hit_row = '0;
    for (int r = 0; r < ROWS; r++) begin
      if (!hit && tab_r[r].valid && tab_r[r].mac == src_mac && tab_r[r].filtering_group_id == key_fid) begin
        hit     = 1'b1;
        hit_row = ROW_W'(r);
      end
    end
  end

  assign clear_ok  = src_valid && hit && (!tab_r[hit_row].pinned || age_pinned_entries_r);
  assign src_known = src_known_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_known_r <= 1'b0;
    end else begin
      src_known_r <= src_valid & hit;
    end
  end

  // ****************************************************************
  // Table store: insert over activity clear over sweep
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int r = 0; r < ROWS; r++) begin
        tab_r[r] <= '0;
      end
    end else begin
      if (do_del) begin
        tab_r[row_r].valid <= 1'b0;
      end else if (do_up) begin
        tab_r[row_r].age <= cur.age + AGE_W'(1);
      end
      if (clear_ok) begin
        tab_r[hit_row].age <= '0;
      end
      if (ins_valid) begin
        tab_r[ins_row] <= ins_entry;
      end
    end
  end

endmodule
